// file: hw/group_protect_host.sv
`include "group_protect_params.svh"

// What this block does
// - send 4C 03 1D 41 then 80
// - five address cycles, group in fourth
// - confirm 10h, wait busy, read status 70h, then FFh
// - set feature 90h with 10 00 00 00
// - zero-address program freezes protection
// - read status 70h after disable
// - run disable once groups are done
module group_protect_host
	import group_protect_pkg::*;
#(
	parameter int MAX_STEPS = 16
) (
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire group_protect_pkg::req_s req,
	input  wire logic                    req_valid,
	output logic                         req_ready,
	output group_protect_pkg::rsp_s      rsp,
	output logic                         rsp_valid,
	output logic                         cle,
	output logic                         ale,
	output logic                         we_n,
	output logic                         re_n,
	output logic                         wp_n,
	output logic                         ce_n,
	output logic [7:0]                   io_out,
	output logic                         io_oe_n,
	input  wire logic [7:0]              io_in,
	input  wire logic                    rb_n,
	input  wire logic                    wp_enable
);
	import group_protect_pkg::*;

	// the step programmes below are written for exactly sixteen steps
	if (MAX_STEPS != 16) begin : g_bad_steps
		$error("MAX_STEPS must be 16");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] rb_sync_r;
	logic       rb_ready_r;
	logic [7:0] io_s1_r, io_s2_r, io_s3_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rb_sync_r  <= 3'h0;
			rb_ready_r <= 1'b0;
		end else begin
			rb_sync_r <= {rb_sync_r[1:0], rb_n};
			if (rb_sync_r[1] == rb_sync_r[2])
				rb_ready_r <= rb_sync_r[2];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			io_s1_r <= 8'h00;
			io_s2_r <= 8'h00;
			io_s3_r <= 8'h00;
		end else begin
			io_s1_r <= io_in;
			io_s2_r <= io_s1_r;
			io_s3_r <= io_s2_r;
		end
	end

	// ----------------------------------------------------------------
	// step programme for each operation
	// ----------------------------------------------------------------
	localparam logic [1:0] K_CMD = 2'h0;
	localparam logic [1:0] K_ADR = 2'h1;
	localparam logic [1:0] K_DAT = 2'h2;
	localparam logic [1:0] K_RD  = 2'h3;

	// returns {last, busy_wait, kind, byte} for step idx of op
	function automatic logic [11:0] step_of(input op_e op, input logic [3:0] grp,
		input logic [3:0] idx);
		logic [11:0] s;
		s = {1'b1, 1'b0, K_CMD, `CMD_EXIT};
		unique case (op)
			OP_PROTECT: begin
				unique case (idx)
					4'h0: s = {2'b00, K_CMD, `CMD_EN0};
					4'h1: s = {2'b00, K_CMD, `CMD_EN1};
					4'h2: s = {2'b00, K_CMD, `CMD_EN2};
					4'h3: s = {2'b00, K_CMD, `CMD_EN3};
					4'h4: s = {2'b00, K_CMD, `CMD_PROG_SETUP};
					4'h5, 4'h6, 4'h7, 4'h9: s = {2'b00, K_ADR, `BYTE_ZERO};
					4'h8: s = {2'b00, K_ADR, 4'h0, grp};
					4'hA: s = {2'b01, K_CMD, `CMD_PROG_CONFIRM};
					4'hB: s = {2'b00, K_CMD, `CMD_READ_STATUS};
					4'hC: s = {2'b00, K_RD, `BYTE_ZERO};
					default: s = {2'b11, K_CMD, `CMD_EXIT};
				endcase
			end
			OP_DISABLE: begin
				unique case (idx)
					4'h0: s = {2'b00, K_CMD, `CMD_SET_FEATURE};
					4'h1: s = {2'b00, K_ADR, `FEAT_ADDR_LOCK};
					4'h2: s = {2'b01, K_DAT, `FEAT_P1_DISABLE};
					4'h3, 4'h4, 4'h5: s = {2'b00, K_DAT, `BYTE_ZERO};
					4'h6: s = {2'b00, K_CMD, `CMD_PROG_SETUP};
					4'h7, 4'h8, 4'h9, 4'hA, 4'hB: s = {2'b00, K_ADR, `BYTE_ZERO};
					4'hC: s = {2'b00, K_DAT, `BYTE_ZERO};
					4'hD: s = {2'b01, K_CMD, `CMD_PROG_CONFIRM};
					4'hE: s = {2'b00, K_CMD, `CMD_READ_STATUS};
					default: s = {2'b10, K_RD, `BYTE_ZERO};
				endcase
			end
			OP_CHECK: begin
				unique case (idx)
					4'h0: s = {2'b00, K_CMD, `CMD_READ_SETUP};
					4'h1, 4'h2, 4'h3, 4'h4, 4'h5: s = {2'b00, K_ADR, `BYTE_ZERO};
					4'h6: s = {2'b01, K_CMD, `CMD_READ_CONFIRM};
					default: s = {2'b10, K_RD, `BYTE_ZERO};
				endcase
			end
			OP_STATUS: begin
				if (idx == 4'h0)
					s = {2'b00, K_CMD, `CMD_READ_STATUS};
				else
					s = {2'b10, K_RD, `BYTE_ZERO};
			end
			default: s = {2'b11, K_CMD, `CMD_EXIT};
		endcase
		return s;
	endfunction

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_SETUP = 5'b00010,
		S_PULSE = 5'b00100,
		S_BUSY  = 5'b01000,
		S_DONE  = 5'b10000
	} state_e;

	state_e      state_r;
	req_s        cur_r;
	logic [3:0]  idx_r;
	logic [3:0]  cnt_r;
	logic        rd_cap_r;
	logic [11:0] step;
	logic        step_last, step_busy;
	logic [1:0]  step_kind;

	always_comb begin
		step      = step_of(cur_r.op, cur_r.group, idx_r);
		step_last = step[11];
		step_busy = step[10];
		step_kind = step[9:8];
	end

	// refusing a bad group here keeps a stray code off the bus entirely
	logic req_ok;
	always_comb
		req_ok = (req.op != OP_PROTECT) || (req.group < `NUM_GROUPS);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r     <= S_IDLE;
			cur_r       <= '0;
			idx_r       <= 4'h0;
			cnt_r       <= 4'h0;
		end else begin
			unique case (state_r)
				S_IDLE: if (req_valid && req_ok) begin
					cur_r   <= req;
					idx_r   <= 4'h0;
					cnt_r   <= 4'h0;
					state_r <= S_SETUP;
				end
				S_SETUP: begin
					cnt_r   <= 4'h0;
					state_r <= S_PULSE;
				end
				S_PULSE: if (cnt_r == 4'(`T_WC_CYC - 1)) begin
					cnt_r       <= 4'h0;
					if (step_busy)
						state_r <= S_BUSY;
					else if (step_last)
						state_r <= S_DONE;
					else begin
						idx_r   <= idx_r + 4'h1;
						state_r <= S_SETUP;
					end
				end else
					cnt_r <= cnt_r + 4'h1;
				// busy may not show until tWB; then wait for ready again
				S_BUSY: begin
					if (cnt_r != 4'(`T_WB_CYC))
						cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'(`T_WB_CYC) && rb_ready_r) begin
						idx_r   <= idx_r + 4'h1;
						state_r <= step_last ? S_DONE : S_SETUP;
					end
				end
				S_DONE: state_r <= S_IDLE;
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pins and answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cle     <= 1'b0;
			ale     <= 1'b0;
			we_n    <= 1'b1;
			re_n    <= 1'b1;
			ce_n    <= 1'b1;
			io_out  <= 8'h00;
			io_oe_n <= 1'b1;
			wp_n    <= 1'b0;
		end else begin
			wp_n <= wp_enable;
			ce_n <= (state_r == S_IDLE) || (state_r == S_DONE);
			if (state_r == S_SETUP) begin
				cle     <= (step_kind == K_CMD);
				ale     <= (step_kind == K_ADR);
				io_out  <= step[7:0];
				io_oe_n <= (step_kind == K_RD);
				we_n    <= (step_kind == K_RD);
				re_n    <= (step_kind != K_RD);
			end else if (state_r == S_PULSE && cnt_r == 4'(`T_WC_CYC - 2)) begin
				we_n <= 1'b1;
				re_n <= 1'b1;
			end else if (state_r != S_PULSE) begin
				cle     <= 1'b0;
				ale     <= 1'b0;
				io_oe_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp       <= '0;
			rsp_valid <= 1'b0;
			req_ready <= 1'b0;
			rd_cap_r  <= 1'b0;
		end else begin
			req_ready <= (state_r == S_IDLE) && !(req_valid && req_ok);
			rsp_valid <= (state_r == S_DONE);
			// io_s3_r lags the pins by three edges: one cycle after the read
			// pulse ends it holds the byte seen while the read strobe was low
			rd_cap_r  <= (state_r == S_PULSE) && (step_kind == K_RD)
				&& (cnt_r == 4'(`T_WC_CYC - 1));
			if (rd_cap_r) begin
				rsp.status_byte <= io_s3_r;
				rsp.pass        <= (cur_r.op == OP_CHECK) ? 1'b1
					: (io_s3_r == `SR_PASS);
				rsp.disabled    <= (io_s3_r == `BYTE_ZERO)
					|| (io_s3_r == `SR_REJECT);
			end
		end
	end

endmodule // group_protect_host

// file: hw/group_protect_params.svh
`ifndef GROUP_PROTECT_PARAMS_SVH
`define GROUP_PROTECT_PARAMS_SVH

`define CMD_EN0          8'h4C
`define CMD_EN1          8'h03
`define CMD_EN2          8'h1D
`define CMD_EN3          8'h41
`define CMD_PROG_SETUP   8'h80
`define CMD_PROG_CONFIRM 8'h10
`define CMD_EXIT         8'hFF
`define CMD_SET_FEATURE  8'hEF
`define CMD_READ_STATUS  8'h70
`define CMD_READ_SETUP   8'h00
`define CMD_READ_CONFIRM 8'h30
`define FEAT_ADDR_LOCK   8'h90
`define FEAT_P1_DISABLE  8'h10
`define BYTE_ZERO        8'h00
`define BYTE_ONES        8'hFF
`define NUM_GROUPS       4'hC
`define SR_PASS          8'hE0
`define SR_FAIL          8'hE1
`define SR_REJECT        8'h60
`define SR_BIT_READY     5
`define SR_BIT_FAIL      0
`define ADDR_CYCLES      3'h5
`define GROUP_ADDR_IDX   3'h3
`define FEAT_P_CYCLES    3'h4
`define SEQ_WIDTH        4'h4
// bus cycle timing: 30 ns min write/read cycle, held in ns
`define T_WC_NS          30
`define T_WB_NS          100
`define CLK_NS           10
`define T_WC_CYC         ((`T_WC_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WB_CYC         ((`T_WB_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: hw/group_protect_pkg.sv
package group_protect_pkg;

	typedef enum logic [2:0] {
		OP_PROTECT = 3'h0,
		OP_DISABLE = 3'h1,
		OP_CHECK   = 3'h2,
		OP_STATUS  = 3'h3,
		OP_EXIT    = 3'h4
	} op_e;

	typedef struct packed {
		op_e        op;
		logic [3:0] group;
	} req_s;

	typedef struct packed {
		logic [7:0] status_byte;
		logic       disabled;
		logic       pass;
	} rsp_s;

	// one bus cycle on the flash pins
	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       re;
		logic [7:0] data;
	} step_s;

endpackage

// file: verification/group_protect_checker.sv
module group_protect_checker
	import group_protect_pkg::*;
(
	input wire logic                    clk,
	input wire logic                    resetn,
	input wire group_protect_pkg::req_s req,
	input wire logic                    req_valid,
	input wire logic                    req_ready,
	input wire logic                    rsp_valid,
	input wire logic                    cle,
	input wire logic                    ale,
	input wire logic                    we_n,
	input wire logic                    re_n,
	input wire logic                    ce_n,
	input wire logic                    wp_n,
	input wire logic [7:0]              io_out,
	input wire logic                    io_oe_n,
	input wire logic                    rb_n,
	input wire logic                    wp_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_take;
		req_valid && req_ready && !(req.op == OP_PROTECT && req.group >= 4'hC);
	endsequence
	sequence s_bad;
		req_valid && req_ready && req.op == OP_PROTECT && req.group >= 4'hC;
	endsequence
	property p_wp; $past(resetn) |-> wp_n == $past(wp_enable); endproperty
	property p_cs; (!we_n || !re_n) |-> !ce_n; endproperty
	property p_drv; !we_n |-> !io_oe_n; endproperty
	property p_rel; !re_n |-> io_oe_n; endproperty
	property p_lat; !(cle && ale) && (we_n || re_n); endproperty
	property p_hold; $rose(we_n) |-> $stable(io_out) && $stable(cle) && $stable(ale); endproperty
	property p_busy; !rb_n [*4] |-> we_n && re_n; endproperty
	property p_take; s_take |=> !req_ready && !rsp_valid [*3]; endproperty
	property p_bad; s_bad |=> req_ready && !rsp_valid; endproperty
	property p_pulse; rsp_valid |-> !req_ready ##1 !rsp_valid; endproperty
	a_wp: assert property (p_wp) else $error("wp_n does not follow wp_enable");
	a_cs: assert property (p_cs) else $error("strobe without chip enable");
	a_drv: assert property (p_drv) else $error("write strobe with bus released");
	a_rel: assert property (p_rel) else $error("read strobe with bus driven");
	a_lat: assert property (p_lat) else $error("latch enables or strobes collide");
	a_hold: assert property (p_hold) else $error("bus moved at write strobe rise");
	a_busy: assert property (p_busy) else $error("strobe while device busy");
	a_take: assert property (p_take) else $error("request not taken cleanly");
	a_bad: assert property (p_bad) else $error("out of range group was taken");
	a_pulse: assert property (p_pulse) else $error("answer pulse too long");
endmodule // group_protect_checker

bind group_protect_host group_protect_checker u_chk (
	.clk(clk), .resetn(resetn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .ce_n(ce_n),
	.wp_n(wp_n), .io_out(io_out), .io_oe_n(io_oe_n), .rb_n(rb_n), .wp_enable(wp_enable)
);

// file: verification/nand_dev_model.sv
module nand_dev_model #(
	parameter int PROG_CYC = 30,
	parameter int REJ_CYC  = 12,
	parameter int REJ_ECC  = 20,
	parameter bit ECC_ON   = 1'b0
) (
	input  wire logic       clk,
	input  wire logic       cle,
	input  wire logic       ale,
	input  wire logic       we_n,
	input  wire logic       re_n,
	input  wire logic       ce_n,
	input  wire logic       wp_n,
	input  wire logic [7:0] bus,
	output logic [7:0]      dout,
	output logic            rb_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// no reset: protection outlives any host reset
	logic [47:0] blk  = '0;
	logic [7:0]  sr   = 8'hE0;
	logic [7:0]  lat;
	logic [7:0]  rdv;
	logic [2:0]  pre  = '0;
	logic [2:0]  ac   = '0;
	logic [3:0]  grp  = '0;
	logic [1:0]  mode = '0;
	logic [1:0]  feat = '0;
	logic        frz  = 1'b0;
	logic        st   = 1'b0;
	logic        hold = 1'b0;
	logic        wq   = 1'b1;
	int          busy = 0;
	wire         ok   = mode == 2'h1 && wp_n && !frz && grp < 4'hC;
	assign rb_n = busy == 0;
	assign rdv  = st ? {sr[7:6], rb_n, sr[4:0]} : {8{!(mode == 2'h3 && frz)}};
	// bus shows the inverse until a read strobe, then holds the read value until the next write strobe, so a stale sample cannot pass
	assign dout = (!re_n || hold) ? rdv : ~rdv;
	always @(posedge clk) begin
		wq <= we_n;
		if (busy > 0) busy <= busy - 1;
		if (!we_n) lat <= bus;
		if (!re_n) hold <= 1'b1;
		if (!we_n) hold <= 1'b0;
		if (we_n && !wq && !ce_n) begin
			pre <= '0;
			if (cle) begin
				if (pre < 4 && lat == 8'(32'h4C031D41 >> (8 * (3 - pre)))) pre <= pre + 1;
				st <= lat == 8'h70;
				case (lat)
					8'h80: begin
						ac <= '0;
						if (pre == 4) mode <= 2'h1;
						else if (mode == 2'h1) mode <= '0;
					end
					8'h10: begin
						busy <= PROG_CYC;
						sr <= (mode == 2'h1 && !ok) ? 8'hE1 : 8'hE0;
						if (ok) blk[4 * grp +: 4] <= 4'hF;
						if (mode == 2'h3) frz <= 1'b1;
						if (mode == 2'h3 && frz) sr <= 8'h60;
						if (mode == 2'h3 && frz) busy <= ECC_ON ? REJ_ECC : REJ_CYC;
					end
					8'hEF: feat <= 2'h1;
					8'h30: busy <= 3;
					8'hFF: mode <= '0;
					default: ;
				endcase
			end else if (ale) begin
				if (feat == 2'h1 && lat == 8'h90) feat <= 2'h2;
				ac <= ac + 1;
				if (ac == 3) grp <= lat[3:0];
			end else begin
				if (feat == 2'h2 && lat == 8'h10) mode <= 2'h3;
				feat <= '0;
			end
		end
	end
endmodule // nand_dev_model

// file: verification/permanent_group_protect_seq_test.sv
module permanent_group_protect_seq_test
	import group_protect_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk       = 1'b0;
	logic       resetn    = 1'b0;
	logic       req_valid = 1'b0;
	logic       wp_enable = 1'b1;
	req_s       req       = '0;
	rsp_s       rsp;
	rsp_s       r;
	logic       req_ready, rsp_valid, cle, ale, we_n, re_n, wp_n, ce_n, io_oe_n, rb_n;
	logic [7:0] io_out, io_in, dout;
	int         miscompares = 0;
	int         compares    = 0;
	always #5 clk = ~clk;
	assign io_in = io_oe_n ? dout : io_out;
	group_protect_host DUT (
		.clk(clk), .resetn(resetn), .req(req), .req_valid(req_valid), .req_ready(req_ready),
		.rsp(rsp), .rsp_valid(rsp_valid), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
		.wp_n(wp_n), .ce_n(ce_n), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in),
		.rb_n(rb_n), .wp_enable(wp_enable)
	);
	nand_dev_model dev (
		.clk(clk), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .ce_n(ce_n),
		.wp_n(wp_n), .bus(io_in), .dout(dout), .rb_n(rb_n)
	);
	// ----------------------------------------
	// checking and bus helpers
	// ----------------------------------------
	task automatic report_and_stop();
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic bad(input logic [47:0] a, input logic [47:0] e);
		miscompares++;
		$display("MISMATCH t=%0t got %h exp %h", $time, a, e);
	endtask
	task automatic cmp_rsp(input rsp_s a, input rsp_s e);
		compares++;
		if (a !== e) bad(a, e);
	endtask
	task automatic cmp_blk(input logic [47:0] a, input logic [47:0] e);
		compares++;
		if (a !== e) bad(a, e);
	endtask
	// a request with ans set that is not answered within the bound ends the run
	task automatic run(input op_e op, input logic [3:0] g, input bit ans = 1'b1);
		int n;
		@(negedge clk);
		req = '{op: op, group: g};
		req_valid = 1'b1;
		for (n = 0; req_ready !== 1'b1 && n < 50; n++) @(negedge clk);
		if (n == 50) begin
			bad(n, 50);
			report_and_stop();
		end
		@(negedge clk);
		req_valid = 1'b0;
		for (n = 0; rsp_valid !== 1'b1 && n < (ans ? 3000 : 300); n++) @(negedge clk);
		if (!ans) cmp_blk(n, 300);
		else if (n == 3000) begin
			bad(n, 3000);
			report_and_stop();
		end
		r = rsp;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		repeat (2) @(negedge clk);
		cmp_blk({req_ready, wp_n, rsp_valid}, 3'h0);
		resetn = 1'b1;
		cmp_blk(dev.blk, 48'h0);
		run(OP_CHECK, 4'h0);
		cmp_blk(r.disabled, 1'b0);
	endtask
	task automatic t_edges();
		run(OP_PROTECT, 4'h0);
		cmp_rsp(r, '{8'hE0, 1'b0, 1'b1});
		run(OP_PROTECT, 4'hB);
		cmp_blk(dev.blk, 48'hF << 44 | 48'hF);
		run(OP_STATUS, 4'h0);
		cmp_rsp(r, '{8'hE0, 1'b0, 1'b1});
		run(OP_EXIT, 4'h0);
	endtask
	task automatic t_wp_low();
		wp_enable = 1'b0;
		run(OP_PROTECT, 4'h5);
		wp_enable = 1'b1;
		cmp_rsp(r, '{8'hE1, 1'b0, 1'b0});
		cmp_blk(dev.blk, 48'hF << 44 | 48'hF);
		run(OP_PROTECT, 4'hC, 1'b0);
		run(OP_PROTECT, 4'h1);
		cmp_blk(dev.blk, 48'hF << 44 | 48'hF0 | 48'hF);
	endtask
	task automatic t_freeze();
		run(OP_DISABLE, 4'h0);
		cmp_rsp(r, '{8'hE0, 1'b0, 1'b1});
		run(OP_CHECK, 4'h0);
		cmp_blk(r.disabled, 1'b1);
		run(OP_PROTECT, 4'h5);
		cmp_rsp(r, '{8'hE1, 1'b0, 1'b0});
		cmp_blk(dev.blk, 48'hF << 44 | 48'hF0 | 48'hF);
		run(OP_DISABLE, 4'h0);
		cmp_rsp(r, '{8'h60, 1'b1, 1'b0});
	endtask
	initial begin
		t_reset();
		t_edges();
		t_wp_low();
		t_freeze();
		report_and_stop();
	end
endmodule // permanent_group_protect_seq_test
